// ### dv/sbw_host.sv
`timescale 1ns/10ps
`default_nettype none
module sbw_host
  import sbw_pkg::*;
(
  input  wire logic        order_i,
  input  wire logic [2:0]  cmd_i,
  input  wire logic        oe_n_i,
  input  wire logic [2:0]  sel_i,
  input  wire logic [35:0] wdata_i,
  input  wire logic [3:0]  lanes_n_i,
  output logic      [35:0] data_o,
  output logic             gw_n_o,
  output logic             we_n_o,
  output logic      [3:0]  bl_n_o,
  output logic             cs1_n_o,
  output logic             cs2_o,
  output logic             cs3_n_o,
  output logic             ps_n_o,
  output logic             cs_n_o,
  output logic             step_n_o,
  output logic             order_o,
  output logic             oe_n_o
);
  // ****
  // cmd: 0 hold, 1 read, 2 byte write, 3 global write, 4 step, 5 write on, 6 stream read
  // ****
  logic start_wr;
  assign start_wr = (cmd_i == 3'd2) || (cmd_i == 3'd3);
  assign ps_n_o   = (cmd_i != 3'd1);
  assign cs_n_o   = !(start_wr || (cmd_i == 3'd6));
  assign step_n_o = (cmd_i != 3'd4);
  assign gw_n_o   = (cmd_i != 3'd3);
  assign we_n_o   = !((cmd_i == 3'd2) || (cmd_i == 3'd5));
  assign bl_n_o   = we_n_o ? 4'hf : lanes_n_i;
  // released lines show the inverse so stale data never reads as good
  assign data_o   = (start_wr || (cmd_i == 3'd5)) ? wdata_i : ~wdata_i;
  assign {cs1_n_o, cs2_o, cs3_n_o} = sel_i;
  assign oe_n_o   = start_wr ? 1'b1 : oe_n_i;
  // order held static, moved only while reset holds
  assign order_o  = order_i;
endmodule : sbw_host
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
  import sbw_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [2:0]  cmd   = 3'd0;
  logic        ord   = 1'b1;
  logic        oe_n  = 1'b0;
  logic [2:0]  sel   = 3'b010;
  logic [14:0] addr  = 15'h0000;
  logic [35:0] wd    = 36'h0_0000_0000;
  logic [3:0]  ln    = 4'hf;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0000_0000;
  wire  [35:0] data_p;
  wire  [35:0] dlo;
  wire  [3:0]  dloe;
  wire  [3:0]  bl_n;
  wire  [31:0] wdo;
  wire         gw_n, we_n, cs1_n, cs2, cs3_n, ps_n, cs_n, step_n, order, oe_p_n, ack;
  int          errors  = 0;
  int          checked = 0;

  always #2.5 clk_i = ~clk_i;

  sbw_host i_sbw_host (.order_i(ord), .cmd_i(cmd), .oe_n_i(oe_n), .sel_i(sel),
    .wdata_i(wd), .lanes_n_i(ln), .data_o(data_p), .gw_n_o(gw_n), .we_n_o(we_n),
    .bl_n_o(bl_n), .cs1_n_o(cs1_n), .cs2_o(cs2), .cs3_n_o(cs3_n), .ps_n_o(ps_n),
    .cs_n_o(cs_n), .step_n_o(step_n), .order_o(order), .oe_n_o(oe_p_n));

  sbw_ctrl i_sbw_ctrl (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .data_lane_i(data_p),
    .data_lane_o(dlo), .data_lane_oe_o(dloe), .global_write_n_i(gw_n),
    .write_enable_n_i(we_n), .byte_lane_write_n_i(bl_n), .chip_select_primary_n_i(cs1_n),
    .chip_select_high_i(cs2), .chip_select_low_n_i(cs3_n), .processor_addr_strobe_n_i(ps_n),
    .controller_addr_strobe_n_i(cs_n), .burst_step_n_i(step_n),
    .burst_order_select_i(order), .output_enable_n_i(oe_p_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(wdo), .wb_ack_o(ack));

  // ****
  // shared tasks
  // ****
  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic pin(input logic [2:0] c, input logic [14:0] a,
                     input logic [35:0] d = 36'h0, input logic [3:0] l = 4'hf,
                     input logic [2:0] s = 3'b010);
    @(posedge clk_i);
    cmd  <= c;
    addr <= a;
    wd   <= d;
    ln   <= l;
    sel  <= s;
  endtask : pin

  task automatic wr(input logic [2:0] c, input logic [14:0] a, input logic [35:0] d,
                    input logic [3:0] l = 4'hf, input logic [2:0] s = 3'b010);
    pin(c, a, d, l, s);
    pin(3'd0, a);
  endtask : wr

  // data and enable appear one edge after the strobe is sampled
  task automatic rd(input logic [14:0] a, input logic [35:0] exp, input logic [3:0] eoe);
    pin(3'd1, a);
    pin(3'd0, a);
    repeat (2) @(posedge clk_i);
    #1;
    chk("lane_oe", {32'h0, dloe}, {32'h0, eoe});
    if (eoe != 4'h0)
      chk("rdata", dlo, exp);
  endtask : rd

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
      errors++;
    q = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // ****
  // scenarios
  // ****
  task automatic t_regs;
    logic [31:0] q;
    wb(1'b1, SBW_REG_WRCNT, 32'h0, q);
    wb(1'b0, SBW_REG_CTRL, 32'h0, q);
    chk("ctrl_rst", {4'h0, q}, {4'h0, SBW_CTRL_RST});
    wr(3'd3, 15'h0500, 36'h0_1111_2222);
    wb(1'b0, SBW_REG_WRCNT, 32'h0, q);
    chk("wrcnt", {4'h0, q}, 36'h1);
    wb(1'b1, SBW_REG_CTRL, 32'h1, q);
    wr(3'd3, 15'h0500, 36'h0_3333_4444);
    rd(15'h0500, 36'h0_1111_2222, 4'hf);
    wb(1'b0, SBW_REG_CTRL, 32'h0, q);
    chk("ctrl", {4'h0, q}, 36'h1);
    wb(1'b1, SBW_REG_CTRL, 32'h0, q);
    wb(1'b0, 8'h0C, 32'h0, q);
    chk("unmapped", {4'h0, q}, {4'h0, SBW_UNMAPPED_READ});
  endtask : t_regs

  task automatic t_lanes;
    logic [35:0] m;
    logic [35:0] n;
    m = 36'h1_2345_6789;
    n = 36'hf_edcb_a987;
    wr(3'd3, 15'h0200, m);
    rd(15'h0200, m, 4'hf);
    for (int i = 0; i < 4; i++)
    begin
      wr(3'd2, 15'h0200, n, ~(4'h1 << i));
      m[i*9 +: 9] = n[i*9 +: 9];
      rd(15'h0200, m, 4'hf);
    end
    wr(3'd2, 15'h0200, ~n, 4'hf);
    rd(15'h0200, n, 4'hf);
    wr(3'd2, 15'h0200, ~n, 4'h0);
    rd(15'h0200, ~n, 4'hf);
  endtask : t_lanes

  task automatic t_enable;
    logic [2:0] s;
    wr(3'd3, 15'h0300, 36'h0_aaaa_5555);
    for (int k = 0; k < 3; k++)
    begin
      s = (k == 0) ? 3'b110 : ((k == 1) ? 3'b000 : 3'b011);
      wr(3'd3, 15'h0300, 36'h0, 4'hf, s);
      rd(15'h0300, 36'h0_aaaa_5555, 4'hf);
    end
  endtask : t_enable

  task automatic t_burst;
    logic [31:0] q;
    logic [31:0] e;
    for (int k = 0; k < 4; k++)
      wr(3'd3, 15'h0404 | 15'(k), 36'h1_0000_0000 | 36'(k));
    pin(3'd1, 15'h0407);
    // first word stands one edge after the strobe is registered
    for (int j = 0; j < 5; j++)
    begin
      pin((j < 3) ? 3'd4 : 3'd0, 15'h0407);
      #1;
      if (j >= 1)
        chk("burst", dlo, 36'h1_0000_0000 | 36'(3 ^ (j - 1)));
    end
    e = (32'h0000_0001 << SBW_STAT_ENABLED) | (32'h0000_0001 << SBW_STAT_READING)
      | (32'h0000_0001 << SBW_STAT_ORDER) | (32'h0000_000f << SBW_STAT_LANE_LSB);
    wb(1'b0, SBW_REG_STATUS, 32'h0000_0000, q);
    chk("status", {4'h0, q}, {4'h0, e});
  endtask : t_burst

  task automatic t_oe;
    @(posedge clk_i);
    oe_n <= 1'b1;
    rd(15'h0200, 36'h0, 4'h0);
    @(posedge clk_i);
    oe_n <= 1'b0;
    pin(3'd3, 15'h0600, 36'h0_0f0f_0f0f);
    pin(3'd5, 15'h0600, 36'h0_0f0f_0f0f, 4'h0);
    pin(3'd5, 15'h0600, 36'h0_0f0f_0f0f, 4'h0);
    pin(3'd0, 15'h0600);
    #1;
    chk("wr_oe", {32'h0, dloe}, 36'h0);
    @(posedge clk_i);
    #1;
    chk("wr_oe", {32'h0, dloe}, 36'h0);
  endtask : t_oe

  // non-burst ties: a fresh controller strobe every cycle
  task automatic t_stream;
    for (int k = 0; k < 4; k++)
      pin(3'd3, 15'h0700 + 15'(k), 36'h2_0000_0000 | 36'(k));
    for (int k = 0; k < 6; k++)
    begin
      pin((k < 4) ? 3'd6 : 3'd0, 15'h0700 + 15'(k));
      #1;
      if (k >= 2)
        chk("stream", dlo, 36'h2_0000_0000 | 36'(k - 2));
    end
  endtask : t_stream

  // order strap is only moved while reset holds the block
  task automatic t_linear;
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    ord   <= SBW_ORDER_LINEAR;
    @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("rst_oe", {32'h0, dloe}, 36'h0);
    pin(3'd1, 15'h0405);
    for (int j = 0; j < 5; j++)
    begin
      pin((j < 3) ? 3'd4 : 3'd0, 15'h0405);
      #1;
      if (j >= 1)
        chk("linear", dlo, 36'h1_0000_0000 | 36'(j % 4));
    end
  endtask : t_linear

  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_lanes;
    t_enable;
    t_burst;
    t_oe;
    t_stream;
    t_linear;
    close_out;
  end

  // whole run needs well under a thousand cycles
  initial
  begin
    #(5000 * 5);
    errors++;
    close_out;
  end
endmodule : tb
`default_nettype wire

// ### logic/sbw_burst.sv
`timescale 1ns/10ps
`default_nettype none
module sbw_burst
  import sbw_pkg::*;
#(
  parameter int unsigned W = SBW_BURST_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_low_i,
  input  wire logic         step_i,
  input  wire logic         order_i,
  output logic      [W-1:0] next_low_o
);

  logic [W-1:0] base;
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // the count wraps after four steps, as the two-bit counter does
  assign next_count = step_i ? W'(count + 1'b1) : count;

  always_comb
  begin
    if (load_i)
      next_low_o = load_low_i;
    else if (order_i == SBW_ORDER_LINEAR)
      next_low_o = W'(base + next_count);
    else
      next_low_o = base ^ next_count;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      base  <= '0;
      count <= '0;
    end
    else if (load_i)
    begin
      base  <= load_low_i;
      count <= '0;
    end
    else
      count <= next_count;
  end

endmodule : sbw_burst
`default_nettype wire

// ### logic/sbw_ctrl.sv
// Overview of operation
// - write when global low, or enable plus lane
// - byte write only lanes with select low
// - enabled: primary low, high high, low low
// - output enable ignored during a write
// - interleaved from 11 gives 10, 01, 00
// - global write low writes every lane
// - advance low steps the burst count
//
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module sbw_ctrl
  import sbw_pkg::*;
#(
  parameter int unsigned AW    = SBW_ADDR_W,
  parameter int unsigned LANES = SBW_LANES,
  parameter int unsigned LW    = SBW_LANE_W
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [AW-1:0]       addr_i,
  input  wire logic [LANES*LW-1:0] data_lane_i,
  output logic      [LANES*LW-1:0] data_lane_o,
  output logic      [LANES-1:0]    data_lane_oe_o,
  input  wire logic                global_write_n_i,
  input  wire logic                write_enable_n_i,
  input  wire logic [LANES-1:0]    byte_lane_write_n_i,
  input  wire logic                chip_select_primary_n_i,
  input  wire logic                chip_select_high_i,
  input  wire logic                chip_select_low_n_i,
  input  wire logic                processor_addr_strobe_n_i,
  input  wire logic                controller_addr_strobe_n_i,
  input  wire logic                burst_step_n_i,
  input  wire logic                burst_order_select_i,
  input  wire logic                output_enable_n_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o
);

  // ****************************************
  // decode functions
  // ****************************************
  function automatic logic [LANES-1:0] lane_decode(input logic gw_n,
                                                   input logic we_n,
                                                   input logic [LANES-1:0] bl_n);
    if (!gw_n)
      lane_decode = '1;
    else if (!we_n)
      lane_decode = ~bl_n;
    else
      lane_decode = '0;
  endfunction : lane_decode

  function automatic logic chip_ok(input logic pri_n,
                                   input logic hi,
                                   input logic lo_n);
    chip_ok = !pri_n && hi && !lo_n;
  endfunction : chip_ok

  // ****************************************
  // input registers
  // ****************************************
  logic [AW-1:0]       s_addr;
  logic [LANES*LW-1:0] s_data;
  logic                s_gw_n;
  logic                s_we_n;
  logic [LANES-1:0]    s_bl_n;
  logic                s_cs_pri_n;
  logic                s_cs_hi;
  logic                s_cs_lo_n;
  logic                s_processor_addr_strobe_n_n;
  logic                s_controller_addr_strobe_n_n;
  logic                s_step_n;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_addr     <= '0;
      s_data     <= '0;
      s_gw_n     <= 1'b1;
      s_we_n     <= 1'b1;
      s_bl_n     <= '1;
      s_cs_pri_n <= 1'b1;
      s_cs_hi    <= 1'b0;
      s_cs_lo_n  <= 1'b1;
      s_processor_addr_strobe_n_n   <= 1'b1;
      s_controller_addr_strobe_n_n   <= 1'b1;
      s_step_n   <= 1'b1;
    end
    else
    begin
      s_addr     <= addr_i;
      s_data     <= data_lane_i;
      s_gw_n     <= global_write_n_i;
      s_we_n     <= write_enable_n_i;
      s_bl_n     <= byte_lane_write_n_i;
      s_cs_pri_n <= chip_select_primary_n_i;
      s_cs_hi    <= chip_select_high_i;
      s_cs_lo_n  <= chip_select_low_n_i;
      s_processor_addr_strobe_n_n   <= processor_addr_strobe_n_i;
      s_controller_addr_strobe_n_n   <= controller_addr_strobe_n_i;
      s_step_n   <= burst_step_n_i;
    end
  end

  // ****************************************
  // cycle decode
  // ****************************************
  sbw_cycle_t          state;
  sbw_cycle_t          next_state;
  logic [AW-1:0]       addr_hi;
  logic [AW-1:0]       next_addr;
  logic [1:0]          acc_low;
  logic [1:0]          cur_low;
  logic [LANES-1:0]    lanes;
  logic [LANES-1:0]    mem_we;
  logic                enabled;
  logic                processor_addr_strobe_n_go;
  logic                controller_addr_strobe_n_go;
  logic                load;
  logic                step;
  logic                wprot;
  logic [LANES*LW-1:0] rdata;

  assign enabled = chip_ok(s_cs_pri_n, s_cs_hi, s_cs_lo_n);
  // processor strobe is blocked while the primary select is high
  assign processor_addr_strobe_n_go = !s_processor_addr_strobe_n_n && !s_cs_pri_n;
  assign controller_addr_strobe_n_go = !s_controller_addr_strobe_n_n && !processor_addr_strobe_n_go;
  assign lanes   = lane_decode(s_gw_n, s_we_n, s_bl_n);

  always_comb
  begin
    next_state = state;
    load       = 1'b0;
    step       = 1'b0;
    if (processor_addr_strobe_n_go)
    begin
      // a processor-strobed start always reads first
      next_state = enabled ? SBW_READ : SBW_IDLE;
      load       = enabled;
    end
    else if (controller_addr_strobe_n_go)
    begin
      load = enabled;
      if (!enabled)
        next_state = SBW_IDLE;
      else if (|lanes)
        next_state = SBW_WRITE;
      else
        next_state = SBW_READ;
    end
    else if (state != SBW_IDLE)
    begin
      step       = !s_step_n;
      next_state = (|lanes) ? SBW_WRITE : SBW_READ;
    end
  end

  sbw_burst #(
    .W (SBW_BURST_W)
  ) u_burst (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (load),
    .load_low_i (s_addr[1:0]),
    .step_i     (step),
    .order_i    (burst_order_select_i),
    .next_low_o (acc_low)
  );

  assign next_addr = load ? s_addr : {addr_hi[AW-1:2], acc_low};
  assign mem_we    = (next_state == SBW_WRITE && !wprot) ? lanes : '0;

  sbw_mem #(
    .AW    (AW),
    .LANES (LANES),
    .LW    (LW)
  ) u_mem (
    .clk_i     (clk_i),
    .addr_i    (next_addr),
    .lane_we_i (mem_we),
    .wdata_i   (s_data),
    .rdata_o   (rdata)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state   <= SBW_IDLE;
      addr_hi <= '0;
      cur_low <= '0;
    end
    else
    begin
      state   <= next_state;
      addr_hi <= next_addr;
      cur_low <= next_addr[1:0];
    end
  end

  // ****************************************
  // data lane drive
  // ****************************************
  assign data_lane_o = rdata;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      data_lane_oe_o <= '0;
    else if (next_state == SBW_READ && !output_enable_n_i)
      data_lane_oe_o <= '1;
    else
      data_lane_oe_o <= '0;
  end

  // ****************************************
  // wishbone slave
  // ****************************************
  logic [31:0] ctrl;
  logic [31:0] wrcnt;
  logic [3:0]  last_lanes;
  logic        wb_req;
  logic        wb_wr;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i;
  assign wprot  = ctrl[SBW_CTRL_WPROT];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl <= SBW_CTRL_RST;
    else if (wb_wr && wb_adr_i == SBW_REG_CTRL)
    begin
      for (int b = 0; b < 4; b++)
        if (wb_sel_i[b])
          ctrl[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
    end
  end

  // a write cycle in the same edge as a clear still counts once
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wrcnt <= SBW_WRCNT_RST;
    else if (wb_wr && wb_adr_i == SBW_REG_WRCNT)
      wrcnt <= (|mem_we) ? 32'h0000_0001 : SBW_WRCNT_RST;
    else if (|mem_we)
      wrcnt <= wrcnt + 32'h0000_0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      last_lanes <= '0;
    else if (|mem_we)
      last_lanes <= mem_we;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= SBW_UNMAPPED_READ;
    else if (wb_req && !wb_we_i)
    begin
      case (wb_adr_i)
        SBW_REG_STATUS:
        begin
          wb_dat_o                              <= SBW_UNMAPPED_READ;
          wb_dat_o[SBW_STAT_ENABLED]            <= (state != SBW_IDLE);
          wb_dat_o[SBW_STAT_WRITING]            <= (state == SBW_WRITE);
          wb_dat_o[SBW_STAT_READING]            <= (state == SBW_READ);
          wb_dat_o[SBW_STAT_ORDER]              <= burst_order_select_i;
          wb_dat_o[SBW_STAT_LOW_LSB +: 2]       <= cur_low;
          wb_dat_o[SBW_STAT_LANE_LSB +: 4]      <= last_lanes;
        end
        SBW_REG_CTRL:  wb_dat_o <= ctrl;
        SBW_REG_WRCNT: wb_dat_o <= wrcnt;
        default:       wb_dat_o <= SBW_UNMAPPED_READ;
      endcase
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  global_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!s_gw_n && next_state == SBW_WRITE && !wprot) |-> mem_we == '1)
    else $error("global write did not hit every lane");

  byte_lane_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_gw_n && !s_we_n && next_state == SBW_WRITE && !wprot) |-> mem_we == ~s_bl_n)
    else $error("byte lane write mismatch");

  write_detect_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (controller_addr_strobe_n_go && enabled) |=>
      ((state == SBW_WRITE) == (!$past(s_gw_n) || (!$past(s_we_n) && !(&$past(s_bl_n))))))
    else $error("write or read decided wrongly");

  chip_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((processor_addr_strobe_n_go || controller_addr_strobe_n_go) && !(!s_cs_pri_n && s_cs_hi && !s_cs_lo_n)) |=> state == SBW_IDLE)
    else $error("disabled chip started a cycle");

  oe_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == SBW_WRITE |-> data_lane_oe_o == '0)
    else $error("lanes driven during write");

  interleave_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (load && s_addr[1:0] == 2'h3 && burst_order_select_i) ##1
    (step && !load && burst_order_select_i) |-> acc_low == 2'h2)
    else $error("interleaved step from 11 not 10");

  linear_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (step && !load && burst_order_select_i == SBW_ORDER_LINEAR && $stable(burst_order_select_i))
      |-> acc_low == 2'(cur_low + 2'h1))
    else $error("linear step did not advance by one");

  strobe_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (processor_addr_strobe_n_i && controller_addr_strobe_n_i) |=> !load)
    else $error("address loaded without a captured strobe");

  write_all_c: cover property (@(posedge clk_i) disable iff (rst_i) mem_we == '1);
  inter_burst_c: cover property (@(posedge clk_i) disable iff (rst_i)
    step && burst_order_select_i ##1 step ##1 step);
  read_drive_c: cover property (@(posedge clk_i) disable iff (rst_i)
    state == SBW_READ && data_lane_oe_o == '1);

endmodule : sbw_ctrl
`default_nettype wire

// ### logic/sbw_mem.sv
`timescale 1ns/10ps
`default_nettype none
module sbw_mem
  import sbw_pkg::*;
#(
  parameter int unsigned AW    = SBW_ADDR_W,
  parameter int unsigned LANES = SBW_LANES,
  parameter int unsigned LW    = SBW_LANE_W
) (
  input  wire logic                clk_i,
  input  wire logic [AW-1:0]       addr_i,
  input  wire logic [LANES-1:0]    lane_we_i,
  input  wire logic [LANES*LW-1:0] wdata_i,
  output logic      [LANES*LW-1:0] rdata_o
);

  logic [LANES*LW-1:0] array [2**AW];

  // read-before-write: a write cycle returns the old word, never driven out
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (lane_we_i[i])
        array[addr_i][i*LW +: LW] <= wdata_i[i*LW +: LW];
    end
    rdata_o <= array[addr_i];
  end

endmodule : sbw_mem
`default_nettype wire

// ### logic/sbw_pkg.sv
package sbw_pkg;

  // ****************************************
  // array geometry
  // ****************************************
  localparam int unsigned SBW_ADDR_W = 15;
  localparam int unsigned SBW_LANES  = 4;
  localparam int unsigned SBW_LANE_W = 9;
  localparam int unsigned SBW_DATA_W = SBW_LANES * SBW_LANE_W;
  localparam int unsigned SBW_BURST_W = 2;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] SBW_REG_STATUS = 8'h00;
  localparam logic [7:0] SBW_REG_CTRL   = 8'h04;
  localparam logic [7:0] SBW_REG_WRCNT  = 8'h08;

  // status fields
  localparam int unsigned SBW_STAT_ENABLED  = 0;
  localparam int unsigned SBW_STAT_WRITING  = 1;
  localparam int unsigned SBW_STAT_READING  = 2;
  localparam int unsigned SBW_STAT_ORDER    = 3;
  localparam int unsigned SBW_STAT_LOW_LSB  = 4;
  localparam int unsigned SBW_STAT_LANE_LSB = 8;

  // control fields and reset values
  localparam int unsigned SBW_CTRL_WPROT     = 0;
  localparam logic [31:0] SBW_CTRL_RST       = 32'h0000_0000;
  localparam logic [31:0] SBW_WRCNT_RST      = 32'h0000_0000;
  localparam logic [31:0] SBW_UNMAPPED_READ  = 32'h0000_0000;

  // ****************************************
  // burst order and cycle state
  // ****************************************
  localparam logic SBW_ORDER_LINEAR = 1'b0;

  typedef enum logic [1:0] {
    SBW_IDLE  = 2'b00,
    SBW_READ  = 2'b01,
    SBW_WRITE = 2'b10
  } sbw_cycle_t;

endpackage : sbw_pkg
